/* File: src/bfvs_pkg.sv */
// Constants and types shared by the breath flow valve sequencer
package bfvs_pkg;
  // Counter and code widths
  localparam int CNT_W = 10;
  localparam int FLOW_W = 5;
  localparam int STAIR_W = 6;
  localparam int TIDAL_LO_W = 4;
  localparam int TIDAL_HI_W = 5;
  localparam int TIDAL_W = TIDAL_LO_W + TIDAL_HI_W;
  // Counter tap positions
  localparam int FLOW_LSB = 1;
  localparam int FLOW_MSB = FLOW_LSB + FLOW_W - 1;
  localparam int STAIR_MSB = STAIR_W - 1;
  localparam int TIDAL_LO_MSB = TIDAL_LO_W - 1;
  localparam int TIDAL_MSB = TIDAL_W - 1;
  localparam int BLINK_BIT = 8;
  localparam int INTEG_RST_BIT = 9;
  // Timing figures in their own units
  localparam int CLK_HZ = 20_000_000;
  localparam int OSC_HZ = 1500;
  localparam int DEBOUNCE_MS = 10;
  // Derived cycle and tick counts
  localparam int PRESCALE_CYCLES = CLK_HZ / OSC_HZ;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * OSC_HZ + 999) / 1000;
  // Analog calibration figures kept for reference by the front end
  localparam int FLOW_MAX_LPM = 63;
  localparam int RATE_MIN_BPM = 6;
  localparam int RATE_MAX_BPM = 40;
  localparam int RATE_THRESH_MV = 4000;
  localparam int CAL_DUTY_PCT = 50;
  localparam int TIDAL_MAX_ML = 1500;
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
  localparam logic [FLOW_W-1:0] FLOW_RST = 5'h00;
  localparam logic [STAIR_W-1:0] STAIR_RST = 6'h00;
  localparam logic [TIDAL_LO_W-1:0] TIDAL_LO_RST = 4'h0;
  localparam logic [TIDAL_HI_W-1:0] TIDAL_HI_RST = 5'h00;
  // Breath phase
  typedef enum logic {BFVS_EXPIRE, BFVS_INSPIRE} bfvs_phase_t;
endpackage

/* File: src/bfvs_timing_if.sv */
// Timing counter carrier between the time base and the sequencer
`timescale 1ns/1ns
interface bfvs_timing_if;
  logic tick; // Pulses for one cycle together with each counter step
  logic [bfvs_pkg::CNT_W-1:0] count; // Free-running breath timing count
  modport source (output tick, output count);
  modport sink (input tick, input count);
endinterface

/* File: src/bfvs_timebase.sv */
// Oscillator divider and free-running breath timing counter
`timescale 1ns/1ns
module bfvs_timebase #(
  parameter int PRESCALE = bfvs_pkg::PRESCALE_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Counter out
  bfvs_timing_if.source tb
);
  localparam int PRE_W = $clog2(PRESCALE + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;
  localparam logic [bfvs_pkg::CNT_W-1:0] CNT_ONE = 10'h001;

  logic [PRE_W-1:0] pre; // Divider phase
  wire pre_wrap = (pre == PRE_LAST);

  // Divider emulates the slow oscillator; counter wraps on its own
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pre <= PRE_ZERO;
      tb.tick <= 1'b0;
      tb.count <= bfvs_pkg::CNT_RST;
    end else if (ce) begin
      tb.tick <= pre_wrap;
      if (pre_wrap) begin
        pre <= PRE_ZERO;
        tb.count <= tb.count + CNT_ONE;
      end else begin
        pre <= pre + PRE_W'(1);
      end
    end
  end

  chk_counter_step: assert property (@(posedge mclk) disable iff (!rstn)
    ce && pre_wrap |=> tb.count == $past(tb.count) + CNT_ONE && tb.tick)
    else $error("timing counter did not step");
endmodule // bfvs_timebase

/* File: src/bfvs_debounce.sv */
// Synchroniser and debouncer for the manual cycle button
`timescale 1ns/1ns
module bfvs_debounce (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Slow tick pacing the stability count
  input wire logic tick,
  // Button
  input wire logic button_raw,
  output logic button_clean
);
  localparam int DB_W = $clog2(bfvs_pkg::DEBOUNCE_TICKS + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(bfvs_pkg::DEBOUNCE_TICKS - 1);

  logic sync_a; // First stage, read only by sync_b
  logic sync_b; // Settled level
  logic [DB_W-1:0] stable; // Ticks the new level has held

  // Level must hold for the full debounce time before it is believed
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      stable <= '0;
      button_clean <= 1'b0;
    end else if (ce) begin
      sync_a <= button_raw;
      sync_b <= sync_a;
      if (sync_b == button_clean) begin
        stable <= '0;
      end else if (tick) begin
        if (stable == DB_LAST) begin
          button_clean <= sync_b;
          stable <= '0;
        end else begin
          stable <= stable + DB_W'(1);
        end
      end
    end
  end

  chk_debounce_hold: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(button_clean) |-> $past(sync_b) == button_clean && $past(tick))
    else $error("button level changed without a full debounce");
endmodule // bfvs_debounce

/* File: src/bfvs_sequencer.sv */
// Breath flow valve sequencer: timing taps, code latches, breath phase
// Contract
// - Timing counter runs freely, wraps, about 1500 Hz
// - Ten counter stages, all used for timing
// - Counter bits weights 2..32 select valves
// - Low six bits feed flow staircase
// - Low nine bits captured as tidal code
// - Weight 256 bit blinks the alarm pulser
// - Weight 512 bit resets both tidal integrators
// - Limit integrator held reset during counts 512 to 1023
// - Flow comparator rise latches flow code
// - Staircase span keeps flow at most 63
// - Valve drive is flow bit AND inspiration
// - Tidal comparator rise latches tidal code
// - Limit rise loads tidal unless OR high
// - Volume alarm comparator drives pulsed alarm
// - Volume comparator drop ends inspiration
// - Expiration held until next breath start
// - Rate comparator starts new breath cycle
// - Rate comparator rise becomes breath start pulse
// - Manual cycle honoured only in expiration
// - Rate span 6 to 40 per minute
// - Gated valve bits also feed flow DAC
// - Inspiration gate calibrated to 50 percent
// - Exhaust drive energised throughout inspiration
`timescale 1ns/1ns
module bfvs_sequencer #(
  parameter int PRESCALE = bfvs_pkg::PRESCALE_CYCLES
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Comparator levels from the analog side
  input wire logic flow_comparator,
  input wire logic tidal_comparator,
  input wire logic tidal_limit_comparator,
  input wire logic volume_comparator,
  input wire logic rate_comparator,
  input wire logic volume_alarm_comparator,
  // Front panel
  input wire logic manual_cycle_button,
  // Valve and DAC codes
  output logic [bfvs_pkg::FLOW_W-1:0] valve_drive,
  output logic [bfvs_pkg::FLOW_W-1:0] flow_dac_code,
  output logic [bfvs_pkg::STAIR_W-1:0] staircase_code,
  output logic [bfvs_pkg::FLOW_W-1:0] flow_code_latch,
  output logic [bfvs_pkg::TIDAL_LO_W-1:0] tidal_latch_low,
  output logic [bfvs_pkg::TIDAL_HI_W-1:0] tidal_latch_high,
  // Breath phase
  output logic inspiration,
  output logic exhaust_drive,
  output logic breath_start,
  output logic breath_reset,
  // Integrator resets and alarm
  output logic limit_integ_reset,
  output logic gating_integ_reset,
  output logic alarm_blink,
  output logic volume_alarm_drive
);
  // Timing counter shared with the time base
  bfvs_timing_if tb ();

  // Free-running counter and oscillator divider
  bfvs_timebase #(
    .PRESCALE(PRESCALE)
  ) u_timebase (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .tb(tb)
  );

  logic button_clean; // Debounced button level

  // Button filtering, paced by the counter tick
  bfvs_debounce u_debounce (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .tick(tb.tick),
    .button_raw(manual_cycle_button),
    .button_clean(button_clean)
  );

  // Previous comparator levels for edge detection
  logic flow_q;
  logic tidal_q;
  logic limit_q;
  logic volume_q;
  logic rate_q;
  logic button_q;

  // Breath phase state
  bfvs_pkg::bfvs_phase_t phase;
  bfvs_pkg::bfvs_phase_t next_phase;

  // Counter taps, all ten stages used
  wire [bfvs_pkg::CNT_W-1:0] cnt = tb.count;
  wire [bfvs_pkg::FLOW_W-1:0] cnt_flow =
    cnt[bfvs_pkg::FLOW_MSB:bfvs_pkg::FLOW_LSB];
  wire [bfvs_pkg::STAIR_W-1:0] cnt_stair = cnt[bfvs_pkg::STAIR_MSB:0];
  wire [bfvs_pkg::TIDAL_LO_W-1:0] cnt_tlo = cnt[bfvs_pkg::TIDAL_LO_MSB:0];
  wire [bfvs_pkg::TIDAL_HI_W-1:0] cnt_thi =
    cnt[bfvs_pkg::TIDAL_MSB:bfvs_pkg::TIDAL_LO_W];
  wire blink_tap = cnt[bfvs_pkg::BLINK_BIT];
  wire integ_tap = cnt[bfvs_pkg::INTEG_RST_BIT];

  // Edges of comparator levels
  wire flow_rise = flow_comparator & ~flow_q;
  wire tidal_rise = tidal_comparator & ~tidal_q;
  wire limit_rise = tidal_limit_comparator & ~limit_q;
  wire volume_fall = ~volume_comparator & volume_q;
  wire rate_rise = rate_comparator & ~rate_q;
  wire button_rise = button_clean & ~button_q;

  // Tidal load OR: normal tidal trip, or the limit if OR not already high
  wire tidal_load_or = tidal_comparator;
  wire limit_load = limit_rise & ~tidal_load_or;
  wire tidal_load = tidal_rise | limit_load;

  // Phase decode
  wire in_insp = (phase == bfvs_pkg::BFVS_INSPIRE);
  wire in_exp = (phase == bfvs_pkg::BFVS_EXPIRE);

  // Manual cycle only counts while no gas is flowing
  wire manual_ok = button_rise & in_exp;

  // Either the rate trip or an honoured button starts a breath
  // No minimum spacing is imposed, so the whole 6 to 40 per minute span fits
  wire start_req = rate_rise | manual_ok;

  // Volume drop closes inspiration unless a new breath starts now
  wire end_req = in_insp & volume_fall & ~start_req;

  // Next latched codes
  wire [bfvs_pkg::FLOW_W-1:0] next_flow =
    flow_rise ? cnt_flow : flow_code_latch;
  wire [bfvs_pkg::TIDAL_LO_W-1:0] next_tlo =
    tidal_load ? cnt_tlo : tidal_latch_low;
  wire [bfvs_pkg::TIDAL_HI_W-1:0] next_thi =
    tidal_load ? cnt_thi : tidal_latch_high;

  // Valve gate, each bit ANDed with the inspiration state
  wire [bfvs_pkg::FLOW_W-1:0] gated_flow;
  for (genvar gi = 0; gi < bfvs_pkg::FLOW_W; gi++) begin : g_valve_gate
    // One AND per valve; a stale code cannot open a valve in expiration
    assign gated_flow[gi] = flow_code_latch[gi] & in_insp;
  end

  // Phase transitions; expiration ignores the volume comparator
  always_comb begin
    next_phase = phase;
    case (phase)
      bfvs_pkg::BFVS_EXPIRE: begin
        // Held until a start request
        if (start_req) begin
          next_phase = bfvs_pkg::BFVS_INSPIRE;
        end
      end
      bfvs_pkg::BFVS_INSPIRE: begin
        // Comparator drop ends the gas delivery
        if (end_req) begin
          next_phase = bfvs_pkg::BFVS_EXPIRE;
        end
      end
      default: begin
        next_phase = bfvs_pkg::BFVS_EXPIRE;
      end
    endcase
  end

  // Edge history, frozen with the rest when ce is low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flow_q <= 1'b0;
      tidal_q <= 1'b0;
      limit_q <= 1'b0;
      volume_q <= 1'b0;
      rate_q <= 1'b0;
      button_q <= 1'b0;
    end else if (ce) begin
      flow_q <= flow_comparator;
      tidal_q <= tidal_comparator;
      limit_q <= tidal_limit_comparator;
      volume_q <= volume_comparator;
      rate_q <= rate_comparator;
      button_q <= button_clean;
    end
  end

  // Phase register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase <= bfvs_pkg::BFVS_EXPIRE;
    end else if (ce) begin
      phase <= next_phase;
    end
  end

  // Flow and tidal latches
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flow_code_latch <= bfvs_pkg::FLOW_RST;
      tidal_latch_low <= bfvs_pkg::TIDAL_LO_RST;
      tidal_latch_high <= bfvs_pkg::TIDAL_HI_RST;
    end else if (ce) begin
      flow_code_latch <= next_flow;
      tidal_latch_low <= next_tlo;
      tidal_latch_high <= next_thi;
    end
  end

  // Valve, DAC and staircase codes; one flop late but glitch free
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      valve_drive <= bfvs_pkg::FLOW_RST;
      flow_dac_code <= bfvs_pkg::FLOW_RST;
      staircase_code <= bfvs_pkg::STAIR_RST;
    end else if (ce) begin
      valve_drive <= gated_flow;
      flow_dac_code <= gated_flow;
      staircase_code <= cnt_stair;
    end
  end

  // Phase outputs; exhaust is closed exactly while valves may open
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      inspiration <= 1'b0;
      exhaust_drive <= 1'b0;
      breath_start <= 1'b0;
      breath_reset <= 1'b0;
    end else if (ce) begin
      inspiration <= in_insp;
      exhaust_drive <= in_insp;
      breath_start <= start_req;
      breath_reset <= start_req;
    end
  end

  // Integrator resets and alarm pacing straight from counter taps
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      limit_integ_reset <= 1'b1;
      gating_integ_reset <= 1'b1;
      alarm_blink <= 1'b0;
      volume_alarm_drive <= 1'b0;
    end else if (ce) begin
      limit_integ_reset <= integ_tap;
      gating_integ_reset <= integ_tap;
      alarm_blink <= blink_tap;
      // Blanked every other 256 counts so the lamp blinks
      volume_alarm_drive <= volume_alarm_comparator & ~blink_tap;
    end
  end

  // Flow code taken from the counter on the comparator rise
  chk_flow_capture: assert property (@(posedge mclk) disable iff (!rstn)
    ce && flow_rise |=> flow_code_latch == $past(cnt_flow))
    else $error("flow code not captured on comparator rise");

  // Valves open only during inspiration
  chk_valve_gate: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> valve_drive == ($past(flow_code_latch) & {bfvs_pkg::FLOW_W{$past(in_insp)}}))
    else $error("valve drive not gated by inspiration");

  // Tidal code taken on the tidal comparator rise
  chk_tidal_capture: assert property (@(posedge mclk) disable iff (!rstn)
    ce && tidal_rise |=> {tidal_latch_high, tidal_latch_low} == $past({cnt_thi, cnt_tlo}))
    else $error("tidal code not captured");

  // Limit trip may not overwrite while the OR is already high
  chk_limit_blocked: assert property (@(posedge mclk) disable iff (!rstn)
    ce && tidal_load_or && !tidal_rise |=> $stable({tidal_latch_high, tidal_latch_low}))
    else $error("tidal latch loaded while OR already high");

  // Volume drop ends inspiration and later shuts the valves
  chk_insp_end: assert property (@(posedge mclk) disable iff (!rstn)
    ce && end_req |=> in_exp ##1 (!$past(ce) || (valve_drive == bfvs_pkg::FLOW_RST)))
    else $error("inspiration not ended by volume comparator");

  // Expiration cannot reopen valves without a start
  chk_exp_hold: assert property (@(posedge mclk) disable iff (!rstn)
    in_exp && !(ce && start_req) |=> in_exp)
    else $error("expiration left without a breath start");

  // Exhaust and valves both released in expiration
  chk_exhaust_rel: assert property (@(posedge mclk) disable iff (!rstn)
    ce && in_exp |=> !exhaust_drive && !inspiration && valve_drive == bfvs_pkg::FLOW_RST)
    else $error("exhaust or valves driven in expiration");

  // A start request resets integrators and opens inspiration
  chk_start_reset: assert property (@(posedge mclk) disable iff (!rstn)
    ce && start_req |=> breath_reset && in_insp ##1 (!$past(ce) || exhaust_drive))
    else $error("breath start did not reset and open inspiration");

  // Button during inspiration is ignored
  chk_manual_ignored: assert property (@(posedge mclk) disable iff (!rstn)
    ce && button_rise && in_insp && !rate_rise |=> !breath_reset)
    else $error("manual cycle honoured during inspiration");

  // Integrator resets follow the weight 512 stage
  chk_integ_reset: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> limit_integ_reset == $past(integ_tap) && gating_integ_reset == limit_integ_reset)
    else $error("integrator reset not following counter stage");

  // Alarm blanked by the weight 256 stage
  chk_alarm_blink: assert property (@(posedge mclk) disable iff (!rstn)
    ce && blink_tap |=> !volume_alarm_drive && alarm_blink)
    else $error("volume alarm not blanked by blink stage");

  // Limit trip loads the tidal code while the OR is low
  chk_limit_load: assert property (@(posedge mclk) disable iff (!rstn)
    ce && limit_rise && !tidal_load_or |=>
      {tidal_latch_high, tidal_latch_low} == $past({cnt_thi, cnt_tlo}))
    else $error("limit trip did not load the tidal code");

  // Staircase code shows the low six counter stages
  chk_stair_taps: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> staircase_code == $past(cnt_stair))
    else $error("staircase code not following the counter");

  // Alarm pacing follows the weight 256 stage
  chk_alarm_pace: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> alarm_blink == $past(blink_tap))
    else $error("alarm pacing not following the counter");

  // Exhaust held closed exactly while inspiration is shown
  chk_exhaust_pair: assert property (@(posedge mclk) disable iff (!rstn)
    exhaust_drive == inspiration)
    else $error("exhaust drive differs from inspiration");

  // Flow converter sees the same gated bits as the valves
  chk_dac_pair: assert property (@(posedge mclk) disable iff (!rstn)
    flow_dac_code == valve_drive)
    else $error("flow converter code differs from valve drive");

  // Rate trip gives the start and reset pulses
  chk_rate_start: assert property (@(posedge mclk) disable iff (!rstn)
    ce && rate_rise |=> breath_start && breath_reset)
    else $error("rate trip did not start a breath");

  // Honoured button press opens inspiration
  chk_manual_start: assert property (@(posedge mclk) disable iff (!rstn)
    ce && button_rise && in_exp |=> breath_start && in_insp)
    else $error("manual cycle in expiration not honoured");
endmodule // bfvs_sequencer

/* File: sim/bfvs_far_side.sv */
// Far-side model: flow comparator and delivered-volume integrator
`timescale 1ns/1ns
module bfvs_far_side (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // From the block
  input wire logic [bfvs_pkg::STAIR_W-1:0] staircase_code,
  input wire logic [bfvs_pkg::FLOW_W-1:0] flow_dac_code,
  input wire logic breath_reset,
  // Bench settings
  input wire logic [bfvs_pkg::STAIR_W-1:0] demand,
  input wire logic [15:0] target,
  input wire logic glitch,
  // Comparator levels
  output logic flow_comparator,
  output logic volume_comparator
);
  logic [15:0] delivered; // Integrated flow, in units of 1 L/min per cycle
  // Staircase meets the demanded flow
  assign flow_comparator = (staircase_code == demand);
  // High while short of target; glitch only on bench command
  assign volume_comparator = (delivered < target) || glitch;
  // Integrator, cleared by the breath reset pulse
  always_ff @(posedge mclk) begin
    if (!rstn || breath_reset)
      delivered <= 16'h0000;
    else
      delivered <= delivered + {10'h000, flow_dac_code, 1'b0};
  end
endmodule // bfvs_far_side

/* File: sim/bfvs_sequencer_tb.sv */
// Self-checking bench for the breath flow valve sequencer
`timescale 1ns/1ns
module bfvs_sequencer_tb;
  localparam int PS = 4; // Short prescale: a full wrap takes 4096 cycles
  // Drives
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic tc = 1'b0;
  logic lc = 1'b0;
  logic rc = 1'b0;
  logic vac = 1'b0;
  logic btn = 1'b0;
  logic gl = 1'b0;
  logic ce = 1'b1;
  logic [5:0] demand = 6'h00;
  logic [15:0] target = 16'h0000;
  // Block outputs
  logic fc, vc, insp, exh, bstart, breset, lim, gate, blink, valm;
  logic [4:0] valve, dac, fl, thi;
  logic [5:0] stair;
  logic [3:0] tlo;
  // Bench state
  int miscompares = 0;
  int compares = 0;
  int nstart = 0;
  int gap = 0;
  int n, dur, n0;
  logic [9:0] model = 10'h000; // Counter as the bench reckons it
  logic [5:0] prev_st = 6'h00;
  logic [13:0] prev_l = 14'h0000;
  logic [13:0] q[$]; // Expected latch contents, oldest first
  logic [4:0] ef = 5'h00;
  logic [8:0] et = 9'h000;
  logic [31:0] seed = 32'h00011DE1;
  logic [15:0] snap; // Outputs held while the enable is low

  // Free-running clock
  always #25 mclk = ~mclk;

  bfvs_sequencer #(.PRESCALE(PS)) dut_u (
    .mclk(mclk), .rstn(rstn), .ce(ce),
    .flow_comparator(fc), .tidal_comparator(tc), .tidal_limit_comparator(lc),
    .volume_comparator(vc), .rate_comparator(rc), .volume_alarm_comparator(vac),
    .manual_cycle_button(btn), .valve_drive(valve), .flow_dac_code(dac),
    .staircase_code(stair), .flow_code_latch(fl), .tidal_latch_low(tlo),
    .tidal_latch_high(thi), .inspiration(insp), .exhaust_drive(exh),
    .breath_start(bstart), .breath_reset(breset), .limit_integ_reset(lim),
    .gating_integ_reset(gate), .alarm_blink(blink), .volume_alarm_drive(valm)
  );

  bfvs_far_side far_u (
    .mclk(mclk), .rstn(rstn), .staircase_code(stair), .flow_dac_code(dac),
    .breath_reset(breset), .demand(demand), .target(target), .glitch(gl),
    .flow_comparator(fc), .volume_comparator(vc)
  );

  // Compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Counts, verdict, end of run
  task results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Edges, then the fixed drive delay
  task clk(input int k);
    repeat (k) @(posedge mclk);
    #2;
  endtask

  // Return just after a counter step, so the count holds for a while
  task wait_step();
    logic [5:0] s;
    s = stair;
    while (stair === s) clk(1);
    clk(1);
  endtask

  // New flow demand, never zero and never the current code
  // Changed just after a counter step, so the staircase agrees with the count
  task set_flow();
    wait_step();
    seed = xs(seed);
    demand = 6'(seed % 62) + 6'h02;
    if (demand[5:1] == ef) demand = (demand > 6'h3C) ? 6'h04 : demand + 6'h02;
    ef = demand[5:1];
    q.push_back({ef, et});
    for (int k = 0; k < 400 && fl !== ef; k++) clk(1);
    clk(3);
  endtask

  // Rate rise starts a breath
  task start_breath();
    n0 = nstart;
    rc = 1'b1;
    clk(1);
    check("reset pulse", breset, 1'b1);
    clk(2);
    rc = 1'b0;
    check("reset pulse end", breset, 1'b0);
    check("start", 16'(nstart - n0), 16'h0001);
    check("insp", insp, 1'b1);
    check("exhaust", exh, 1'b1);
    check("valves", valve, ef);
    check("flow dac", dac, ef);
  endtask

  // Wait for volume to end the breath, then try to reopen it
  task end_breath(input int t0);
    n = (target + 2 * ef - 1) / (2 * ef);
    dur = t0;
    while (insp === 1'b1 && dur < 3000) begin
      clk(1);
      dur++;
    end
    check("length", dur + 2 >= n && dur <= n + 4, 1'b1);
    clk(1);
    check("valves shut", valve, 5'h00);
    check("exhaust off", exh, 1'b0);
    gl = 1'b1;
    clk(2);
    gl = 1'b0;
    clk(40);
    check("stays out", insp, 1'b0);
  endtask

  // Counter model, tap checks and latch watcher
  always @(posedge mclk) begin
    if (rstn !== 1'b1) begin
      model <= 10'h000;
      prev_st <= 6'h00;
      prev_l <= 14'h0000;
      gap <= 0;
    end else if (ce === 1'b1) begin
      gap <= gap + 1;
      if (bstart === 1'b1) nstart <= nstart + 1;
      if (stair !== prev_st) begin
        check("stair", stair, 6'(model[5:0] + 6'h01));
        if (model != 10'h000) check("step", 16'(gap + 1), 16'(PS));
        // Mid-range point, clear of any carry into the slow taps
        if (model[7:0] == 8'h7F) begin
          check("blink", blink, model[8]);
          check("limit reset", lim, model[9]);
          check("gating reset", gate, model[9]);
          check("alarm", valm, vac & ~model[8]);
        end
        model <= model + 10'h001;
        prev_st <= stair;
        gap <= 0;
      end
      if ({fl, thi, tlo} !== prev_l) begin
        if (q.size() == 0)
          check("latch unasked", {fl, thi, tlo}, prev_l);
        else
          check("latch", {fl, thi, tlo}, q.pop_front());
        prev_l <= {fl, thi, tlo};
      end
    end
  end

  // Main sequence
  initial begin
    clk(16);
    check("valves", valve, 5'h00);
    check("limit held", lim, 1'b1);
    check("flow code", fl, 5'h00);
    rstn = 1'b1;
    $display("test reset done");
    vac = 1'b1;
    clk(2100);
    vac = 1'b0;
    clk(2100);
    $display("test counter taps done");
    for (int i = 0; i < 3; i++) begin
      set_flow();
      wait_step();
      tc = 1'b1;
      et = model[8:0];
      q.push_back({ef, et});
      clk(3);
      lc = 1'b1;
      clk(2);
      lc = 1'b0;
      tc = 1'b0;
      wait_step();
      lc = 1'b1;
      et = model[8:0];
      q.push_back({ef, et});
      clk(2);
      lc = 1'b0;
      clk(2);
      check("tidal", {thi, tlo}, et);
    end
    $display("test latches done");
    for (int i = 0; i < 3; i++) begin
      set_flow();
      seed = xs(seed);
      target = 16'(seed % 400) + 16'h0064;
      start_breath();
      end_breath(0);
    end
    $display("test breaths done");
    target = 16'(ef) * 16'h0320;
    start_breath();
    n0 = nstart;
    btn = 1'b1;
    clk(150);
    btn = 1'b0;
    clk(120);
    check("press dropped", 16'(nstart - n0), 16'h0000);
    end_breath(270);
    n0 = nstart;
    btn = 1'b1;
    clk(10);
    btn = 1'b0;
    clk(150);
    check("bounce dropped", 16'(nstart - n0), 16'h0000);
    btn = 1'b1;
    for (int k = 0; k < 300 && nstart == n0; k++) clk(1);
    btn = 1'b0;
    check("manual start", 16'(nstart - n0), 16'h0001);
    clk(3);
    end_breath(3);
    $display("test button done");
    // Enable low: every register must hold, counter included
    ce = 1'b0;
    snap = {1'b0, blink, lim, insp, exh, fl, stair};
    clk(40);
    check("frozen", {1'b0, blink, lim, insp, exh, fl, stair}, snap);
    ce = 1'b1;
    clk(8);
    $display("test enable done");
    check("notes left", 16'(q.size()), 16'h0000);
    results();
  end

  // Watchdog, well past the expected run length
  initial begin
    #1500000;
    miscompares++;
    results();
  end
endmodule // bfvs_sequencer_tb
